// *** hdl/cgm_mode_ctrl.v ***
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "cgm_regs.vh"
module cgm_mode_ctrl (
   // clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // axi4-lite write address
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   // axi4-lite write data
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   // axi4-lite write response
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // axi4-lite read
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // chip-level stop and wake
   input  wire        stop_req,
   input  wire        wake_irq,
   input  wire        debug_enable,
   // clock sources
   input  wire        ext_ref_edge,
   input  wire        ext_ref_ok_status,
   input  wire        clock_loss_status,
   input  wire        dco_fail,
   input  wire signed [7:0] count_error,
   input  wire        sample_strobe,
   // generator controls and status
   output reg  [2:0]  gen_state,
   output reg         system_clock_enable,
   output reg         gen_output_enable,
   output reg         digital_osc_enable,
   output reg         int_ref_enable,
   output reg         ext_ref_engaged,
   output reg         loop_ref_internal,
   output reg         crystal_band,
   output reg  [3:0]  output_divide_shift,
   output reg  [2:0]  loop_multiply_factor,
   output reg  [7:0]  internal_reference_trim,
   output reg  [11:0] filter_value,
   output reg         osc_stable_status,
   output reg         loop_locked
);

   // ----------------------------------------
   // state and registers
   // ----------------------------------------
   reg [1:0]  clock_mode_request;
   reg        ref_kind_select;
   reg        crystal_band_select;
   reg        osc_keep_in_stop;
   reg [2:0]  output_divide_ratio;
   reg        trim_loaded = 1'b0;   // power-up value only, no reset clears it
   reg        in_stop;
   reg        off_entry_bypass;
   reg        ext_ever_locked;
   reg        xtal_ready;
   reg [12:0] xtal_count;
   reg [2:0]  lock_count;
   reg [1:0]  avg_count;
   reg signed [9:0] err_sum;
   reg signed [7:0] prev_error;
   reg        have_prev;
   reg [2:0]  next_state;
   reg        aw_hold;
   reg        w_hold;
   reg [7:0]  aw_addr;
   reg [31:0] w_data;
   reg [3:0]  w_strb;

   wire [7:0] err_abs = count_error[7] ? (~count_error + 8'd1) : count_error;
   wire signed [8:0] err_delta = count_error - prev_error;
   wire [8:0] delta_abs = err_delta[8] ? (~err_delta + 9'd1) : err_delta;
   wire       in_lock_win   = err_abs < `CGM_LOCK_WIN;
   wire       out_unlock    = err_abs > `CGM_UNLOCK_WIN;
   wire       ext_usable    = ext_ref_ok_status & (xtal_ready | ~ref_kind_select);
   wire       loop_state    = (gen_state == `CGM_ST_LOOP_INT) ||
                              (gen_state == `CGM_ST_LOOP_EXT);
   wire       wr_go         = aw_hold & w_hold & ~s_axi_bvalid;

   // ----------------------------------------
   // next-state logic
   // ----------------------------------------
   always @* begin
      next_state = gen_state;
      case (gen_state)
         `CGM_ST_OFF: begin
            if (wake_irq) begin
               if (clock_mode_request == 2'b10 && off_entry_bypass)
                  next_state = `CGM_ST_BYPASS;
               else
                  next_state = `CGM_ST_SELF;
            end
         end
         `CGM_ST_SELF: begin
            if (clock_mode_request == 2'b01 && osc_stable_status)
               next_state = `CGM_ST_LOOP_INT;
            else if (clock_mode_request == 2'b11 && ext_usable && osc_stable_status)
               next_state = `CGM_ST_LOOP_EXT;
            else if (clock_mode_request == 2'b10 && ext_usable)
               next_state = `CGM_ST_BYPASS;
         end
         `CGM_ST_LOOP_INT: begin
            if (clock_mode_request == 2'b00)
               next_state = `CGM_ST_SELF;
            else if (clock_mode_request == 2'b11 && ext_usable)
               next_state = `CGM_ST_LOOP_EXT;
         end
         `CGM_ST_BYPASS: begin
            if (clock_mode_request[1] && !ext_ref_ok_status && clock_loss_status)
               next_state = `CGM_ST_SELF;
            else if (clock_mode_request != 2'b10)
               next_state = `CGM_ST_SELF;
         end
         `CGM_ST_LOOP_EXT: begin
            if (clock_mode_request[1] && !ext_ref_ok_status && clock_loss_status)
               next_state = `CGM_ST_SELF;
            else if (dco_fail && ext_ref_ok_status)
               next_state = `CGM_ST_BYPASS;
            else if (clock_mode_request == 2'b00)
               next_state = `CGM_ST_SELF;
            else if (clock_mode_request == 2'b01)
               next_state = `CGM_ST_LOOP_INT;
         end
         default: next_state = `CGM_ST_SELF;
      endcase
      // stop without debug or keep-osc turns everything off
      if (stop_req && !in_stop && !debug_enable && !osc_keep_in_stop)
         next_state = `CGM_ST_OFF;
   end

   // ----------------------------------------
   // mode state, stop handling, crystal count
   // ----------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         gen_state        <= `CGM_ST_SELF;
         in_stop          <= 1'b0;
         off_entry_bypass <= 1'b0;
         ext_ever_locked  <= 1'b0;
         xtal_ready       <= 1'b0;
         xtal_count       <= 13'd0;
      end else begin
         gen_state <= next_state;
         if (stop_req && !in_stop && !debug_enable)
            in_stop <= 1'b1;
         else if (wake_irq)
            in_stop <= 1'b0;
         if (next_state == `CGM_ST_OFF && gen_state != `CGM_ST_OFF) begin
            off_entry_bypass <= (clock_mode_request == 2'b10) & ext_ref_ok_status;
            xtal_ready <= 1'b0;
            xtal_count <= 13'd0;
         end else if (!ref_kind_select || !ext_ref_ok_status) begin
            xtal_ready <= ~ref_kind_select;
            xtal_count <= 13'd0;
         end else if (ext_ref_edge && !xtal_ready) begin
            if (xtal_count == `CGM_XTAL_COUNT - 13'd1)
               xtal_ready <= 1'b1;
            xtal_count <= xtal_count + 13'd1;
         end
         if (gen_state != `CGM_ST_LOOP_EXT)
            ext_ever_locked <= 1'b0;
         else if (loop_locked)
            ext_ever_locked <= 1'b1;
      end
   end

   // ----------------------------------------
   // stability, lock detection, filter update
   // ----------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         osc_stable_status <= 1'b0;
         loop_locked       <= 1'b0;
         lock_count        <= 3'd0;
         avg_count         <= 2'd0;
         err_sum           <= 10'sd0;
         prev_error        <= 8'sd0;
         have_prev         <= 1'b0;
         filter_value      <= `CGM_FILTER_RESET;
      end else begin
         if (gen_state == `CGM_ST_OFF || next_state == `CGM_ST_OFF) begin
            osc_stable_status <= 1'b0;
            have_prev <= 1'b0;
         end else if (sample_strobe && digital_osc_enable) begin
            prev_error <= count_error;
            have_prev  <= 1'b1;
            // only the change between samples counts: a steady non-zero error still reads as stable
            if (have_prev && delta_abs <= {1'b0, `CGM_UNLOCK_WIN})
               osc_stable_status <= 1'b1;
         end
         if (!loop_state || next_state != gen_state) begin
            loop_locked <= 1'b0;
            lock_count  <= 3'd0;
            avg_count   <= 2'd0;
            err_sum     <= 10'sd0;
         end else if (sample_strobe) begin
            if (!loop_locked) begin
               if (in_lock_win) begin
                  if (lock_count == `CGM_LOCK_SAMPLES - 3'd1)
                     loop_locked <= 1'b1;
                  lock_count <= lock_count + 3'd1;
               end else begin
                  lock_count <= 3'd0;
               end
               filter_value <= filter_value - {{4{count_error[7]}}, count_error};
            end else if (out_unlock) begin
               loop_locked <= 1'b0;
               lock_count  <= 3'd0;
               avg_count   <= 2'd0;
               err_sum     <= 10'sd0;
            end else if (avg_count == `CGM_AVG_CYCLES) begin
               // average of four samples, one update per four sample strobes
               filter_value <= filter_value -
                  {{4{err_sum[9]}}, err_sum[9:2]} -
                  {{6{count_error[7]}}, count_error[7:2]};
               avg_count <= 2'd0;
               err_sum   <= 10'sd0;
            end else begin
               avg_count <= avg_count + 2'd1;
               err_sum   <= err_sum + {{2{count_error[7]}}, count_error};
            end
         end
         if (wr_go && aw_addr == `CGM_OFF_FILTER && gen_state == `CGM_ST_SELF &&
             clock_mode_request == 2'b00) begin
            if (w_strb[0]) filter_value[7:0]  <= w_data[7:0];
            if (w_strb[1]) filter_value[11:8] <= w_data[11:8];
         end
      end
   end

   // ----------------------------------------
   // axi4-lite slave and control registers
   // ----------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'b00;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rresp   <= 2'b00;
         s_axi_rdata   <= 32'h0000_0000;
         aw_hold <= 1'b0;
         w_hold  <= 1'b0;
         aw_addr <= 8'h00;
         w_data  <= 32'h0000_0000;
         w_strb  <= 4'h0;
         clock_mode_request      <= `CGM_MODE_RESET;
         ref_kind_select         <= 1'b0;
         crystal_band_select     <= 1'b0;
         osc_keep_in_stop        <= 1'b0;
         loop_multiply_factor    <= `CGM_MFD_RESET;
         output_divide_ratio     <= `CGM_DIV_RESET;
         // trim is not reset: only the power-up load and register writes touch it
      end else begin
         s_axi_awready <= ~aw_hold & ~s_axi_awready & s_axi_awvalid;
         s_axi_wready  <= ~w_hold & ~s_axi_wready & s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_hold <= 1'b0;
            w_hold  <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr == `CGM_OFF_CTRL || aw_addr == `CGM_OFF_TRIM ||
                             aw_addr == `CGM_OFF_FILTER) ? 2'b00 : 2'b10;
            if (aw_addr == `CGM_OFF_CTRL) begin
               if (w_strb[0]) begin
                  clock_mode_request  <= w_data[1:0];
                  ref_kind_select     <= w_data[`CGM_CTRL_REFKIND];
                  crystal_band_select <= w_data[`CGM_CTRL_BAND];
                  osc_keep_in_stop    <= w_data[`CGM_CTRL_KEEPOSC];
                  loop_multiply_factor <= w_data[7:5];
               end
               if (w_strb[1])
                  output_divide_ratio <= w_data[10:8];
            end
            if (aw_addr == `CGM_OFF_TRIM && w_strb[0])
               internal_reference_trim <= w_data[7:0];
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         // hardware fallbacks reflect the new mode in the request field
         if (gen_state == `CGM_ST_LOOP_EXT && next_state == `CGM_ST_BYPASS)
            clock_mode_request <= 2'b10;
         else if (clock_mode_request[1] && next_state == `CGM_ST_SELF &&
                  gen_state != `CGM_ST_SELF && gen_state != `CGM_ST_OFF)
            clock_mode_request <= 2'b00;
         s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'b00;
            case (s_axi_araddr)
               `CGM_OFF_CTRL:   s_axi_rdata <= {21'd0, output_divide_ratio,
                                   loop_multiply_factor, osc_keep_in_stop,
                                   crystal_band_select, ref_kind_select,
                                   clock_mode_request};
               `CGM_OFF_TRIM:   s_axi_rdata <= {24'd0, internal_reference_trim};
               `CGM_OFF_FILTER: s_axi_rdata <= {20'd0, filter_value};
               `CGM_OFF_STATUS: s_axi_rdata <= {24'd0, in_stop, xtal_ready,
                                   loop_locked, osc_stable_status, ext_ref_ok_status,
                                   gen_state};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= 2'b10;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
      // trim survives every reset: loaded once, on the first edge after power-up
      if (!trim_loaded) begin
         trim_loaded             <= 1'b1;
         internal_reference_trim <= `CGM_TRIM_RESET;
      end
   end

   // ----------------------------------------
   // clock source and feed controls
   // ----------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         system_clock_enable <= 1'b1;
         gen_output_enable   <= 1'b1;
         digital_osc_enable  <= 1'b1;
         int_ref_enable      <= 1'b1;
         ext_ref_engaged     <= 1'b0;
         loop_ref_internal   <= 1'b1;
         crystal_band        <= 1'b0;
         output_divide_shift <= 4'd0;
      end else begin
         // keep-osc in stop leaves sources on but gates the feed
         system_clock_enable <= ~(in_stop & osc_keep_in_stop) &
                                (next_state != `CGM_ST_OFF);
         digital_osc_enable  <= (next_state != `CGM_ST_OFF) &&
                                (next_state != `CGM_ST_BYPASS) || (in_stop & osc_keep_in_stop);
         int_ref_enable      <= (next_state != `CGM_ST_BYPASS) &&
                                (next_state != `CGM_ST_OFF);
         gen_output_enable   <= (next_state == `CGM_ST_BYPASS) ? xtal_ready & ext_ref_ok_status
                                : (next_state != `CGM_ST_OFF);
         ext_ref_engaged     <= ext_usable && ((next_state == `CGM_ST_BYPASS) ||
                                (next_state == `CGM_ST_LOOP_EXT));
         // loop external falls back to the internal reference while the external one is unusable
         loop_ref_internal   <= (next_state != `CGM_ST_LOOP_EXT) | ~ext_usable;
         crystal_band        <= ref_kind_select & crystal_band_select;
         if (next_state == `CGM_ST_LOOP_EXT && !ext_ever_locked && !loop_locked)
            output_divide_shift <= {1'b0, output_divide_ratio} + 4'd1;
         else
            output_divide_shift <= {1'b0, output_divide_ratio};
      end
   end

endmodule // cgm_mode_ctrl

// *** hdl/cgm_regs.vh ***
`ifndef CGM_REGS_VH
`define CGM_REGS_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define CGM_OFF_CTRL      8'h00
`define CGM_OFF_TRIM      8'h04
`define CGM_OFF_FILTER    8'h08
`define CGM_OFF_STATUS    8'h0C
`define CGM_OFF_EVENTS    8'h10
// ----------------------------------------
// control field positions
// ----------------------------------------
`define CGM_CTRL_MODE_LO  0
`define CGM_CTRL_REFKIND  2
`define CGM_CTRL_BAND     3
`define CGM_CTRL_KEEPOSC  4
`define CGM_CTRL_MFD_LO   5
`define CGM_CTRL_DIV_LO   8
// ----------------------------------------
// reset values
// ----------------------------------------
`define CGM_MODE_RESET    2'b00
`define CGM_MFD_RESET     3'h0
`define CGM_DIV_RESET     3'h0
`define CGM_TRIM_RESET    8'h80
`define CGM_FILTER_RESET  12'h000
// ----------------------------------------
// state codes
// ----------------------------------------
`define CGM_ST_OFF        3'd0
`define CGM_ST_SELF       3'd1
`define CGM_ST_LOOP_INT   3'd2
`define CGM_ST_BYPASS     3'd3
`define CGM_ST_LOOP_EXT   3'd4
// ----------------------------------------
// lock detection and timing
// ----------------------------------------
`define CGM_XTAL_COUNT    13'd4096
`define CGM_LOCK_WIN      8'd4
`define CGM_UNLOCK_WIN    8'd16
`define CGM_LOCK_SAMPLES  3'd4
`define CGM_AVG_CYCLES    2'd3
`endif

// *** verification/cgm_clk_src.sv ***
`timescale 1ns/1ns
// ----------------------------------------
// loop monitor model: reference edges and error samples
// ----------------------------------------
module cgm_clk_src (
   // clock and reset
   input  wire              aclk,
   input  wire              aresetn,
   // error level chosen by the bench
   input  wire signed [7:0] err_level,
   // monitor outputs
   output reg               ext_ref_edge,
   output reg               sample_strobe,
   output wire signed [7:0] count_error
);
   reg [3:0] cnt;
   // error is only valid with the strobe; scrambled otherwise
   assign count_error = sample_strobe ? err_level : ~err_level;
   // crystal edge at counts 0, 3, 6, 9, 12 and 15 of each 16 cycles, comparison every 8 cycles
   always @(posedge aclk) begin
      if (!aresetn) begin
         cnt <= 4'h0;
         ext_ref_edge <= 1'b0;
         sample_strobe <= 1'b0;
      end else begin
         cnt <= cnt + 4'h1;
         ext_ref_edge <= (cnt % 3 == 0);
         sample_strobe <= (cnt[2:0] == 3'h7);
      end
   end
endmodule // cgm_clk_src

// *** verification/cgm_mode_ctrl_assertions.sv ***
`timescale 1ns/1ns
`include "cgm_regs.vh"
// ----------------------------------------
// mode controller checks
// ----------------------------------------
module cgm_chk (
   // clock, reset and bus handshakes
   input wire       aclk,
   input wire       aresetn,
   input wire       s_axi_bvalid,
   input wire       s_axi_bready,
   input wire       s_axi_rvalid,
   input wire       s_axi_rready,
   // generator state
   input wire [2:0] gen_state,
   input wire       system_clock_enable,
   input wire       digital_osc_enable,
   input wire       int_ref_enable,
   input wire       loop_ref_internal,
   input wire       osc_stable_status,
   input wire       loop_locked
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // enables are registered from next_state and change on the same edge as the state, yet only settled states count
   a_reset_self:
      assert property ($rose(aresetn) |-> gen_state == `CGM_ST_SELF) else $error("not self");
   a_off_feed:
      assert property (gen_state == `CGM_ST_OFF && $stable(gen_state) |-> !system_clock_enable)
      else $error("feed on in off");
   a_off_stable:
      assert property (gen_state == `CGM_ST_OFF && $stable(gen_state) |-> !osc_stable_status)
      else $error("stable flag in off");
   a_self_osc:
      assert property (gen_state == `CGM_ST_SELF && $stable(gen_state) |-> digital_osc_enable)
      else $error("osc off in self");
   a_bypass_off:
      assert property (gen_state == `CGM_ST_BYPASS && $stable(gen_state)
         |-> !digital_osc_enable && !int_ref_enable) else $error("osc on in bypass");
   a_loop_ref:
      assert property (gen_state == `CGM_ST_LOOP_INT && $stable(gen_state) |-> loop_ref_internal)
      else $error("wrong loop reference");
   a_lock_loop:
      assert property (loop_locked |-> gen_state inside {`CGM_ST_LOOP_INT, `CGM_ST_LOOP_EXT}
         || $past(gen_state) inside {`CGM_ST_LOOP_INT, `CGM_ST_LOOP_EXT})
      else $error("lock outside loop");
   a_bresp_hold:
      assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid drop");
   a_rresp_hold:
      assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("rvalid drop");
   c_off: cover property (gen_state == `CGM_ST_OFF);
   c_lock: cover property (loop_locked);
   c_bypass: cover property (gen_state == `CGM_ST_BYPASS);
endmodule // cgm_chk
bind cgm_mode_ctrl cgm_chk cgm_chk_inst (.aclk(aclk), .aresetn(aresetn),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .gen_state(gen_state), .system_clock_enable(system_clock_enable),
   .digital_osc_enable(digital_osc_enable), .int_ref_enable(int_ref_enable),
   .loop_ref_internal(loop_ref_internal), .osc_stable_status(osc_stable_status),
   .loop_locked(loop_locked));

// *** verification/cgm_mode_ctrl_tb.sv ***
`timescale 1ns/1ns
`include "cgm_regs.vh"
// ----------------------------------------
// mode controller bench
// ----------------------------------------
module cgm_mode_ctrl_tb;
   reg aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   reg stop_req, wake_irq, debug_enable, ext_ref_ok_status, clock_loss_status, dco_fail;
   reg [7:0] s_axi_awaddr, s_axi_araddr;
   reg [31:0] s_axi_wdata;
   reg [3:0] s_axi_wstrb;
   reg signed [7:0] err_level;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire ext_ref_edge, sample_strobe, system_clock_enable, gen_output_enable, digital_osc_enable;
   wire int_ref_enable, ext_ref_engaged, loop_ref_internal, crystal_band;
   wire osc_stable_status, loop_locked;
   wire signed [7:0] count_error;
   wire [2:0] gen_state, loop_multiply_factor;
   wire [3:0] output_divide_shift;
   wire [7:0] internal_reference_trim;
   wire [11:0] filter_value;
   reg [31:0] rd;
   reg [1:0] rsp;
   integer mismatches, checks_done, n;
   cgm_mode_ctrl cgm_mode_ctrl_inst (.*);
   cgm_clk_src cgm_clk_src_inst (.*);
   // clock and time-zero values
   initial begin
      aclk = 0;
      forever #4 aclk = ~aclk;
   end
   task conclude;
      begin
         $display("mismatches %0d checks %0d", mismatches, checks_done);
         if (mismatches == 0 && checks_done > 0) $display("Testbench passed");
         else $display("Testbench failed");
         $finish;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         checks_done = checks_done + 1;
         if (got !== exp) begin
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
            mismatches = mismatches + 1;
         end
      end
   endtask
   task timeout;
      begin
         $display("ERROR t=%0t got %h exp %h", $time, gen_state, 3'h7);
         mismatches = mismatches + 1;
         conclude;
      end
   endtask
   // write: address and data offered together, each released when taken
   task axi_wr(input [7:0] a, input [31:0] d);
      begin
         s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1;
         s_axi_bready <= 1; n = 0;
         do begin
            @(posedge aclk); n = n + 1;
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
         end while (!s_axi_bvalid && n < 200);
         rsp = s_axi_bresp; s_axi_bready <= 0;
         if (n >= 200) timeout;
         @(posedge aclk); // one edge between transfers
      end
   endtask
   task axi_rd(input [7:0] a);
      begin
         s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1; n = 0;
         do begin
            @(posedge aclk); n = n + 1;
            if (s_axi_arready) s_axi_arvalid <= 0;
         end while (!s_axi_rvalid && n < 200);
         rd = s_axi_rdata; rsp = s_axi_rresp; s_axi_rready <= 0;
         if (n >= 200) timeout;
         @(posedge aclk); // one edge between transfers
      end
   endtask
   task wait_state(input [2:0] s);
      begin
         n = 0;
         while (gen_state !== s && n < 2000) begin @(posedge aclk); n = n + 1; end
         if (n >= 2000) timeout;
         @(posedge aclk);
      end
   endtask
   task wait_lock;
      begin
         n = 0;
         while (loop_locked !== 1 && n < 2000) begin @(posedge aclk); n = n + 1; end
         if (n >= 2000) timeout;
         @(posedge aclk);
      end
   endtask
   // plain stop and keep-osc stop, each woken by interrupt, then debug stop ended by dropping the request
   task t_stop;
      begin
         stop_req <= 1; wait_state(`CGM_ST_OFF);
         chk(system_clock_enable, 0);
         chk({osc_stable_status, gen_output_enable}, 0);
         stop_req <= 0; wake_irq <= 1; @(posedge aclk); wake_irq <= 0;
         wait_state(`CGM_ST_SELF); chk(system_clock_enable, 1);
         axi_wr(`CGM_OFF_CTRL, 32'h0000_0010); stop_req <= 1; n = 0;
         while (system_clock_enable !== 0 && n < 200) begin @(posedge aclk); n = n + 1; end
         if (n >= 200) timeout;
         chk(digital_osc_enable, 1);
         stop_req <= 0; wake_irq <= 1; @(posedge aclk); wake_irq <= 0;
         wait_state(`CGM_ST_SELF); axi_wr(`CGM_OFF_CTRL, 32'h0000_0000);
         debug_enable <= 1; stop_req <= 1; repeat (20) @(posedge aclk);
         chk({gen_state, system_clock_enable}, {`CGM_ST_SELF, 1'b1});
         stop_req <= 0; debug_enable <= 0;
      end
   endtask
   // filter writes, internal loop, lock and bypass
   task t_modes;
      begin
         axi_wr(`CGM_OFF_FILTER, 32'h0000_0123); chk(rsp, 0); axi_rd(`CGM_OFF_FILTER);
         chk(rd, 32'h0000_0123);
         axi_wr(`CGM_OFF_CTRL, 32'h0000_00A1); wait_state(`CGM_ST_LOOP_INT);
         chk({loop_ref_internal, loop_multiply_factor}, 4'hD);
         axi_wr(`CGM_OFF_FILTER, 32'h0000_0456); axi_rd(`CGM_OFF_FILTER);
         chk(rd, 32'h0000_0123);
         chk(filter_value, 12'h123);
         wait_lock; chk(loop_locked, 1);
         // the internal loop has no direct transition to bypass: go back to self-clocked first
         axi_wr(`CGM_OFF_CTRL, 32'h0000_0000); wait_state(`CGM_ST_SELF);
         chk({loop_locked, digital_osc_enable}, 2'b01);
         axi_wr(`CGM_OFF_CTRL, 32'h0000_0002); wait_state(`CGM_ST_BYPASS);
         chk({digital_osc_enable, int_ref_enable}, 0);
         chk({gen_output_enable, ext_ref_engaged, crystal_band}, 3'b110);
         axi_wr(`CGM_OFF_CTRL, 32'h0000_0000); wait_state(`CGM_ST_SELF);
         axi_wr(`CGM_OFF_CTRL, 32'h0000_0003); wait_state(`CGM_ST_LOOP_EXT);
         chk(output_divide_shift, 1);
         wait_lock; chk(output_divide_shift, 0);
         dco_fail <= 1; wait_state(`CGM_ST_BYPASS); dco_fail <= 0;
         axi_rd(`CGM_OFF_CTRL); chk(rd, 32'h0000_0002);
      end
   endtask
   // trim survives reset; unmapped read refused
   task t_trim;
      begin
         axi_rd(`CGM_OFF_TRIM); chk(rd, 32'h0000_0080);
         axi_wr(`CGM_OFF_TRIM, 32'h0000_005A); chk(internal_reference_trim, 8'h5A);
         aresetn <= 0; repeat (6) @(posedge aclk); aresetn <= 1; @(posedge aclk);
         axi_rd(`CGM_OFF_TRIM); chk(rd, 32'h0000_005A);
         chk(gen_state, `CGM_ST_SELF);
         axi_rd(8'h40); chk(rsp, 2'b10); chk(rd, 32'h0000_0000);
      end
   endtask
   initial begin
      mismatches = 0; checks_done = 0; aresetn = 0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
      {stop_req, wake_irq, debug_enable, clock_loss_status, dco_fail} = 0;
      ext_ref_ok_status = 1; s_axi_awaddr = 0; s_axi_araddr = 0; s_axi_wdata = 0;
      s_axi_wstrb = 4'hF; err_level = 0;
      repeat (6) @(posedge aclk);
      aresetn <= 1; @(posedge aclk);
      t_stop; t_modes; t_trim;
      conclude;
   end
endmodule // cgm_mode_ctrl_tb
